/* File: design/dcei_pkg.sv */
// Package: constants and carrier types for the dual comparator edge interrupt block
package dcei_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int DCEI_NUM_CMP = 2;
	localparam int DCEI_ADDR_W  = 4;
	localparam int DCEI_DATA_W  = 8;
	localparam int DCEI_SEL_W   = 4;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] DCEI_OFF_CTRL [DCEI_NUM_CMP] = '{4'h0, 4'h2};
	localparam logic [3:0] DCEI_OFF_MODE [DCEI_NUM_CMP] = '{4'h1, 4'h3};
	localparam logic [3:0] DCEI_OFF_MUX  [DCEI_NUM_CMP] = '{4'h4, 4'h5};
	localparam logic [3:0] DCEI_OFF_IRQCTL              = 4'h6;
	localparam logic [3:0] DCEI_OFF_IRQSTAT             = 4'h7;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DCEI_CTRL_EN_BIT  = 7;
	localparam int DCEI_CTRL_OUT_BIT = 6;
	localparam int DCEI_CTRL_RIF_BIT = 5;
	localparam int DCEI_CTRL_FIF_BIT = 4;
	localparam int DCEI_CTRL_HYP_LSB = 2;
	localparam int DCEI_CTRL_HYN_LSB = 0;
	localparam int DCEI_MODE_RSV_BIT = 7;
	localparam int DCEI_MODE_RIE_BIT = 5;
	localparam int DCEI_MODE_FIE_BIT = 4;
	localparam int DCEI_MODE_MD_LSB  = 0;
	localparam int DCEI_MUX_POS_LSB  = 0;
	localparam int DCEI_MUX_NEG_LSB  = 4;
	localparam int DCEI_IRQ_GIE_BIT  = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] DCEI_MD_RST  = 2'h2;
	localparam logic [1:0] DCEI_HYS_RST = 2'h0;
	localparam logic [3:0] DCEI_SEL_RST = 4'h0;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic                  en;
		logic [1:0]            hyp;
		logic [1:0]            hyn;
		logic [1:0]            md;
		logic [DCEI_SEL_W-1:0] pos_sel;
		logic [DCEI_SEL_W-1:0] neg_sel;
	} dcei_cfg_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} dcei_flags_t;

endpackage

/* File: design/dcei_top.sv */
// Digital side of two comparators: sync, edge flags, interrupt and registers
`timescale 1ns/1ps
module dcei_top
	import dcei_pkg::*;
(
	// Clock and reset
	input  wire logic                                 CLK_SYS_IN,
	input  wire logic                                 ARST_N_IN,
	// Register port
	input  wire logic [DCEI_ADDR_W-1:0]               ADDR_IN,
	input  wire logic [DCEI_DATA_W-1:0]               WR_DATA_IN,
	input  wire logic                                 WR_IN,
	input  wire logic                                 RD_IN,
	output logic      [DCEI_DATA_W-1:0]               RD_DATA_OUT,
	// Analog comparator results
	input  wire logic [DCEI_NUM_CMP-1:0]              CMP_RAW_IN,
	// Analog configuration
	output dcei_cfg_t [DCEI_NUM_CMP-1:0]              CMP_CFG_OUT,
	// Comparator outputs
	output logic      [DCEI_NUM_CMP-1:0]              CMP_SYNC_OUT,
	output logic      [DCEI_NUM_CMP-1:0]              CMP_ASYNC_OUT,
	// Interrupt
	output logic                                      IRQ_OUT
);

	// ------------------------------------------------------------
	// Shared state
	// ------------------------------------------------------------
	logic [DCEI_DATA_W-1:0]   rd_data_r;
	logic [DCEI_DATA_W-1:0]   rd_data_nxt;
	logic                     gie_r;
	logic                     gie_nxt;
	logic [DCEI_NUM_CMP-1:0]  src_en_r;
	logic [DCEI_NUM_CMP-1:0]  src_en_nxt;
	logic                     irq_r;
	logic                     irq_nxt;
	logic [DCEI_NUM_CMP-1:0]  pend;
	logic [DCEI_DATA_W-1:0]   ctrl_rd [DCEI_NUM_CMP];
	logic [DCEI_DATA_W-1:0]   mode_rd [DCEI_NUM_CMP];
	logic [DCEI_DATA_W-1:0]   mux_rd  [DCEI_NUM_CMP];
	dcei_flags_t [DCEI_NUM_CMP-1:0] flags;
	logic                     wr_irqctl;
	logic                     wr_irqstat;

	assign wr_irqctl  = WR_IN && (ADDR_IN == DCEI_OFF_IRQCTL);
	assign wr_irqstat = WR_IN && (ADDR_IN == DCEI_OFF_IRQSTAT);

	// ------------------------------------------------------------
	// Per comparator logic
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DCEI_NUM_CMP; gi++) begin : g_cmp
			dcei_cfg_t   cfg_r;
			dcei_cfg_t   cfg_nxt;
			logic        rie_r;
			logic        rie_nxt;
			logic        fie_r;
			logic        fie_nxt;
			logic        sync1_r;
			logic        sync2_r;
			logic        prev_r;
			dcei_flags_t flag_r;
			dcei_flags_t flag_nxt;
			logic        wr_ctrl;
			logic        wr_mode;
			logic        wr_mux;
			logic        rise_clr;
			logic        fall_clr;
			logic        rise_set;
			logic        fall_set;

			assign wr_ctrl = WR_IN && (ADDR_IN == DCEI_OFF_CTRL[gi]);
			assign wr_mode = WR_IN && (ADDR_IN == DCEI_OFF_MODE[gi]);
			assign wr_mux  = WR_IN && (ADDR_IN == DCEI_OFF_MUX[gi]);

			// Clear by writing zero to the control flag or one to the status bit
			assign rise_clr = (wr_ctrl && !WR_DATA_IN[DCEI_CTRL_RIF_BIT]) ||
			                  (wr_irqstat && WR_DATA_IN[2*gi]);
			assign fall_clr = (wr_ctrl && !WR_DATA_IN[DCEI_CTRL_FIF_BIT]) ||
			                  (wr_irqstat && WR_DATA_IN[2*gi+1]);
			assign rise_set = sync2_r && !prev_r;
			assign fall_set = !sync2_r && prev_r;

			always_comb begin
				cfg_nxt = cfg_r;
				rie_nxt = rie_r;
				fie_nxt = fie_r;
				if (wr_ctrl) begin
					cfg_nxt.en  = WR_DATA_IN[DCEI_CTRL_EN_BIT];
					cfg_nxt.hyp = WR_DATA_IN[DCEI_CTRL_HYP_LSB +: 2];
					cfg_nxt.hyn = WR_DATA_IN[DCEI_CTRL_HYN_LSB +: 2];
				end
				if (wr_mode) begin
					rie_nxt    = WR_DATA_IN[DCEI_MODE_RIE_BIT];
					fie_nxt    = WR_DATA_IN[DCEI_MODE_FIE_BIT];
					cfg_nxt.md = WR_DATA_IN[DCEI_MODE_MD_LSB +: 2];
				end
				if (wr_mux) begin
					cfg_nxt.pos_sel = WR_DATA_IN[DCEI_MUX_POS_LSB +: DCEI_SEL_W];
					cfg_nxt.neg_sel = WR_DATA_IN[DCEI_MUX_NEG_LSB +: DCEI_SEL_W];
				end
				// Set wins over a clear in the same cycle
				flag_nxt.rise = rise_set || (flag_r.rise && !rise_clr);
				flag_nxt.fall = fall_set || (flag_r.fall && !fall_clr);
			end

			always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
				if (!ARST_N_IN) begin
					cfg_r   <= '{en: 1'b0, hyp: DCEI_HYS_RST, hyn: DCEI_HYS_RST, md: DCEI_MD_RST,
					             pos_sel: DCEI_SEL_RST, neg_sel: DCEI_SEL_RST};
					rie_r   <= 1'b0;
					fie_r   <= 1'b0;
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					prev_r  <= 1'b0;
					flag_r  <= '0;
				end else begin
					cfg_r   <= cfg_nxt;
					rie_r   <= rie_nxt;
					fie_r   <= fie_nxt;
					sync1_r <= CMP_RAW_IN[gi] && cfg_r.en;
					sync2_r <= sync1_r;
					prev_r  <= sync2_r;
					flag_r  <= flag_nxt;
				end
			end

			// Unclocked path stays valid with the clock stopped
			assign CMP_ASYNC_OUT[gi] = CMP_RAW_IN[gi] && cfg_r.en;
			assign CMP_SYNC_OUT[gi]  = sync2_r;
			assign CMP_CFG_OUT[gi]   = cfg_r;
			assign flags[gi]         = flag_r;

			assign pend[gi] = ((flag_r.rise && rie_r) || (flag_r.fall && fie_r)) && src_en_r[gi];

			always_comb begin
				ctrl_rd[gi] = '0;
				ctrl_rd[gi][DCEI_CTRL_EN_BIT]          = cfg_r.en;
				ctrl_rd[gi][DCEI_CTRL_OUT_BIT]         = sync2_r;
				ctrl_rd[gi][DCEI_CTRL_RIF_BIT]         = flag_r.rise;
				ctrl_rd[gi][DCEI_CTRL_FIF_BIT]         = flag_r.fall;
				ctrl_rd[gi][DCEI_CTRL_HYP_LSB +: 2]    = cfg_r.hyp;
				ctrl_rd[gi][DCEI_CTRL_HYN_LSB +: 2]    = cfg_r.hyn;
				mode_rd[gi] = '0;
				mode_rd[gi][DCEI_MODE_RSV_BIT]         = 1'b1;
				mode_rd[gi][DCEI_MODE_RIE_BIT]         = rie_r;
				mode_rd[gi][DCEI_MODE_FIE_BIT]         = fie_r;
				mode_rd[gi][DCEI_MODE_MD_LSB +: 2]     = cfg_r.md;
				mux_rd[gi] = '0;
				mux_rd[gi][DCEI_MUX_POS_LSB +: DCEI_SEL_W] = cfg_r.pos_sel;
				mux_rd[gi][DCEI_MUX_NEG_LSB +: DCEI_SEL_W] = cfg_r.neg_sel;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Interrupt control and read port
	// ------------------------------------------------------------
	always_comb begin
		gie_nxt    = gie_r;
		src_en_nxt = src_en_r;
		if (wr_irqctl) begin
			gie_nxt    = WR_DATA_IN[DCEI_IRQ_GIE_BIT];
			src_en_nxt = WR_DATA_IN[DCEI_NUM_CMP-1:0];
		end
		irq_nxt = gie_r && (|pend);
		rd_data_nxt = '0;
		if (RD_IN) begin
			for (int i = 0; i < DCEI_NUM_CMP; i++) begin
				if (ADDR_IN == DCEI_OFF_CTRL[i]) begin
					rd_data_nxt = ctrl_rd[i];
				end
				if (ADDR_IN == DCEI_OFF_MODE[i]) begin
					rd_data_nxt = mode_rd[i];
				end
				if (ADDR_IN == DCEI_OFF_MUX[i]) begin
					rd_data_nxt = mux_rd[i];
				end
			end
			if (ADDR_IN == DCEI_OFF_IRQCTL) begin
				rd_data_nxt[DCEI_IRQ_GIE_BIT]    = gie_r;
				rd_data_nxt[DCEI_NUM_CMP-1:0]    = src_en_r;
			end
			if (ADDR_IN == DCEI_OFF_IRQSTAT) begin
				for (int i = 0; i < DCEI_NUM_CMP; i++) begin
					rd_data_nxt[2*i]   = flags[i].rise;
					rd_data_nxt[2*i+1] = flags[i].fall;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			gie_r     <= 1'b0;
			src_en_r  <= '0;
			irq_r     <= 1'b0;
			rd_data_r <= '0;
		end else begin
			gie_r     <= gie_nxt;
			src_en_r  <= src_en_nxt;
			irq_r     <= irq_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	assign RD_DATA_OUT = rd_data_r;
	assign IRQ_OUT     = irq_r;

endmodule // dcei_top

/* File: tb/dcei_chk.sv */
// Checker: port assertions for the comparator edge interrupt block
`timescale 1ns/1ps
module dcei_chk
	import dcei_pkg::*;
(
	input wire logic                       CLK_SYS_IN,
	input wire logic                       ARST_N_IN,
	input wire logic [DCEI_ADDR_W-1:0]     ADDR_IN,
	input wire logic [DCEI_DATA_W-1:0]     WR_DATA_IN,
	input wire logic                       WR_IN,
	input wire logic                       RD_IN,
	input wire logic [DCEI_DATA_W-1:0]     RD_DATA_OUT,
	input wire logic [DCEI_NUM_CMP-1:0]    CMP_RAW_IN,
	input wire dcei_cfg_t [DCEI_NUM_CMP-1:0] CMP_CFG_OUT,
	input wire logic [DCEI_NUM_CMP-1:0]    CMP_SYNC_OUT,
	input wire logic [DCEI_NUM_CMP-1:0]    CMP_ASYNC_OUT,
	input wire logic                       IRQ_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!ARST_N_IN);
	chk_async_gate:
	assert property (CMP_ASYNC_OUT == (CMP_RAW_IN & {CMP_CFG_OUT[1].en, CMP_CFG_OUT[0].en})) else $error("async out");
	chk_sync_delay:
	assert property (CMP_SYNC_OUT == $past(CMP_ASYNC_OUT, 2)) else $error("sync latency");
	chk_irq_cause:
	assert property ($rose(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2)
		|| $past(CMP_SYNC_OUT, 2) != $past(CMP_SYNC_OUT, 3)) else $error("irq without cause");
	chk_irq_sticky:
	assert property ($fell(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2)) else $error("irq dropped alone");
	chk_cfg_hold:
	assert property (!$past(WR_IN) |-> $stable(CMP_CFG_OUT)) else $error("cfg changed");
	chk_enable_write:
	assert property ($past(WR_IN) && $past(ADDR_IN) == DCEI_OFF_CTRL[0]
		|-> CMP_CFG_OUT[0].en == $past(WR_DATA_IN[7])) else $error("enable write");
	chk_rd_idle:
	assert property (!$past(RD_IN) |-> RD_DATA_OUT == 8'h00) else $error("read data idle");
	chk_off_second:
	assert property ((!CMP_CFG_OUT[1].en) [*3] |-> !CMP_SYNC_OUT[1]) else $error("disabled sync");
	cover property ($rose(IRQ_OUT));
	cover property ($fell(IRQ_OUT));
	cover property ($rose(CMP_SYNC_OUT[1]));
endmodule // dcei_chk

bind dcei_top dcei_chk dcei_chk_i (.CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .ADDR_IN(ADDR_IN),
	.WR_DATA_IN(WR_DATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RD_DATA_OUT(RD_DATA_OUT), .CMP_RAW_IN(CMP_RAW_IN),
	.CMP_CFG_OUT(CMP_CFG_OUT), .CMP_SYNC_OUT(CMP_SYNC_OUT), .CMP_ASYNC_OUT(CMP_ASYNC_OUT), .IRQ_OUT(IRQ_OUT));

/* File: tb/dcei_ana_model.sv */
// Analog comparator model: raw result from two input voltages
`timescale 1ns/1ps
module dcei_ana_model (
	// Input voltages in millivolts
	input  int   pos_mv_in,
	input  int   neg_mv_in,
	// Raw result
	output logic raw_out
);
	assign raw_out = (pos_mv_in > neg_mv_in);
endmodule // dcei_ana_model

/* File: tb/tb_top.sv */
// Testbench: registers, edge flags and interrupt of the comparator block
`timescale 1ns/1ps
module tb_top
	import dcei_pkg::*;
;
	logic            clk = 1'b0;
	logic            arst_n = 1'b0;
	logic            wr = 1'b0;
	logic            rd = 1'b0;
	logic [3:0]      addr = 4'h0;
	logic [7:0]      wdat = 8'h00;
	logic [7:0]      rdat;
	logic [7:0]      d;
	logic [1:0]      raw;
	logic [1:0]      sy;
	logic [1:0]      asy;
	logic            irq;
	dcei_cfg_t [1:0] cfg;
	int              pmv [2] = '{0, 0};
	int              n_fail = 0;
	int              n_compared = 0;
	logic [3:0]      ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
	logic [7:0]      rx [9] = '{8'h00, 8'h82, 8'h00, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	always #5 clk = ~clk;

	dcei_ana_model ana0 (.pos_mv_in(pmv[0]), .neg_mv_in(100), .raw_out(raw[0]));
	dcei_ana_model ana1 (.pos_mv_in(pmv[1]), .neg_mv_in(100), .raw_out(raw[1]));
	dcei_top dcei_top_i (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WR_DATA_IN(wdat), .WR_IN(wr),
		.RD_IN(rd), .RD_DATA_OUT(rdat), .CMP_RAW_IN(raw), .CMP_CFG_OUT(cfg), .CMP_SYNC_OUT(sy),
		.CMP_ASYNC_OUT(asy), .IRQ_OUT(irq));

	task wrt(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdt(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task wt;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task tally_and_finish;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rdt(ra[i]);
			cmp8("reset value", rx[i], d);
		end
		wrt(4'h1, 8'hA2);
		wrt(4'h6, 8'h81);
		wrt(4'h0, 8'h80);
		wrt(4'h0, 8'h80);
		pmv[0] <= 200;
		wt();
		cmp8("async0", 1'b1, asy[0]);
		cmp8("sync0", 1'b1, sy[0]);
		cmp8("irq rise", 1'b1, irq);
		rdt(4'h0);
		cmp8("ctrl0", 8'hE0, d);
		pmv[0] <= 0;
		wt();
		rdt(4'h0);
		cmp8("ctrl0 fall", 8'hB0, d);
		cmp8("irq held", 1'b1, irq);
		wrt(4'h7, 8'h01);
		rdt(4'h7);
		cmp8("status", 8'h02, d);
		cmp8("irq fall off", 1'b0, irq);
		wrt(4'h1, 8'h92);
		wt();
		cmp8("irq fall on", 1'b1, irq);
		wrt(4'h6, 8'h01);
		wt();
		cmp8("irq global off", 1'b0, irq);
		wrt(4'h6, 8'h81);
		wrt(4'h0, 8'h80);
		wt();
		cmp8("irq cleared", 1'b0, irq);
		wrt(4'h3, 8'hA2);
		wrt(4'h2, 8'h80);
		pmv[1] <= 200;
		wt();
		rdt(4'h7);
		cmp8("status1", 8'h04, d);
		cmp8("irq src off", 1'b0, irq);
		wrt(4'h2, 8'h00);
		#1 cmp8("async1 off", 1'b0, asy[1]);
		wt();
		cmp8("sync1 off", 1'b0, sy[1]);
		rdt(4'h7);
		cmp8("status1 fall", 8'h08, d);
		wrt(4'h4, 8'h5A);
		#1;
		cmp8("pos sel", 8'h0A, {4'h0, cfg[0].pos_sel});
		cmp8("neg sel", 8'h05, {4'h0, cfg[0].neg_sel});
		wrt(4'h7, 8'h0F);
		rdt(4'h7);
		cmp8("status clear", 8'h00, d);
		tally_and_finish();
	end
endmodule // tb_top
